// [fcd_pkg.sv]
package fcd_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFF_CFG  = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_DSR  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PTS  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CMD  = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_XFER = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PCN  = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_DIR  = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_STAT = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_SEQ  = 8'h20;

  // Configuration register fields.
  localparam int CFG_W           = 8;
  localparam int CFG_MFM         = 0;
  localparam int CFG_AUTO_POWERDOWN_ENABLE     = 1;
  localparam int CFG_MIN_POWERUP_DELAY_SEL     = 2;
  localparam int CFG_MT          = 3;
  localparam int CFG_IDLE_MSK    = 4;
  localparam int CFG_COMPAT_STAT = 5;
  localparam int CFG_OSC_PD      = 6;
  localparam int CFG_COMPAT_MODE = 7;
  localparam logic [CFG_W-1:0] CFG_RST = 8'h01;

  // Data-rate select register fields.
  localparam int DSR_W        = 5;
  localparam int DSR_RATE_LSB = 0;
  localparam int DSR_RATE_W   = 2;
  localparam int DSR_PC_LSB   = 2;
  localparam int PC_W         = 3;
  localparam logic [DSR_W-1:0]      DSR_RST = 5'h00;
  localparam logic [DSR_RATE_W-1:0] RATE_2M = 2'h3;

  // Precompensation table: one select bit per drive, drive index above.
  localparam int DRV_W      = 2;
  localparam int NDRV       = 4;
  localparam int PTS_DRV_LSB = 4;
  localparam logic [NDRV-1:0] PTS_RST = 4'h0;

  // Command parameter register fields.
  localparam int CMD_N_LSB    = 0;
  localparam int N_W          = 3;
  localparam int CMD_HEAD     = 3;
  localparam int CMD_START    = 4;
  localparam int CMD_SECT_LSB = 8;
  localparam int CMD_EOT_LSB  = 16;
  localparam int CMD_DTL_LSB  = 24;
  localparam int BYTE_W       = 8;

  // Digital input register status bits.
  localparam int DIR_PD_BIT   = 7;
  localparam int DIR_IDLE_BIT = 6;

  // Status register bits.
  localparam int STAT_PD   = 0;
  localparam int STAT_IDLE = 1;
  localparam int STAT_OSC  = 2;
  localparam int STAT_PU   = 3;

  localparam int LEN_W = 16;
  localparam logic [LEN_W-1:0] SECT_BASE    = 16'h0080;
  localparam logic [BYTE_W-1:0] SECTOR_FIRST = 8'h01;

  // Minimum power-up times.
  localparam int CLK_KHZ     = 100_000;
  localparam int PU_SHORT_MS = 10;
  localparam int PU_LONG_MS  = 500;
  localparam int PU_SHORT_CYC = PU_SHORT_MS * CLK_KHZ;
  localparam int PU_LONG_CYC  = PU_LONG_MS * CLK_KHZ;
  localparam int PU_CNT_W     = 26;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } fcd_reg_req_t;

  typedef struct packed {
    logic              active;
    logic              head;
    logic [BYTE_W-1:0] sector;
  } fcd_seq_t;

  typedef enum logic [1:0] {
    PD_ACTIVE  = 2'b00,
    PD_POWERUP = 2'b01,
    PD_DOWN    = 2'b10
  } fcd_pd_state_t;

endpackage

// [fcd_pu_timer.sv]
`timescale 1ns/1ps
module fcd_pu_timer #(
  parameter int CNT_W = 26
) (
  input  wire logic             clk,
  input  wire logic             reset,
  input  wire logic             ce,
  input  wire logic             start,
  input  wire logic [CNT_W-1:0] load,
  output logic                  busy
);

  logic [CNT_W-1:0] cnt_r;

  // Busy for exactly load cycles after the start cycle.
  always_ff @(posedge clk)
  begin
    if (reset)
      cnt_r <= '0;
    else if (ce)
    begin
      if (start)
        cnt_r <= load;
      else if (cnt_r != '0)
        cnt_r <= cnt_r - CNT_W'(1);
    end
  end

  assign busy = (cnt_r != '0);

  AST_TMR_LOAD: assert property (@(posedge clk) disable iff (reset)
    ce && start && load != '0 |=> busy && cnt_r == $past(load))
    else $error("Power-up timer did not load its count.");

endmodule

// [fcd_top.sv]
`timescale 1ns/1ps
module fcd_top
  import fcd_pkg::*;
#(
  parameter int PU_SHORT = fcd_pkg::PU_SHORT_CYC,
  parameter int PU_LONG  = fcd_pkg::PU_LONG_CYC
) (
  input  wire logic                          clk,
  input  wire logic                          reset,
  input  wire logic                          ce,
  input  wire fcd_pkg::fcd_reg_req_t         req,
  output logic [fcd_pkg::DATA_W-1:0]         rdata,
  input  wire logic                          core_idle,
  input  wire logic                          wake,
  input  wire logic                          sense_done,
  input  wire logic [fcd_pkg::BYTE_W-1:0]    head_position,
  input  wire logic                          sector_done,
  output fcd_pkg::fcd_seq_t                  seq,
  output logic [fcd_pkg::LEN_W-1:0]          xfer_len,
  output logic [fcd_pkg::PC_W-1:0]           precomp_delay,
  output logic                               osc_enable,
  output logic                               powerdown_state,
  output logic                               mfm_mode
);
  import fcd_pkg::*;

  logic [CFG_W-1:0]      cfg_r;
  logic [DSR_W-1:0]      dsr_r;
  logic [NDRV-1:0]       pts_r;
  logic [DRV_W-1:0]      drv_r;
  logic [N_W-1:0]        n_r;
  logic                  head_r;
  logic [BYTE_W-1:0]     sect_r;
  logic [BYTE_W-1:0]     eot_r;
  logic [BYTE_W-1:0]     dtl_r;
  logic [BYTE_W-1:0]     pcn_r;
  logic [LEN_W-1:0]      xfer_r;
  logic [PC_W-1:0]       pc_r;
  logic                  osc_en_r;
  logic [DATA_W-1:0]     rdata_r;
  logic [DATA_W-1:0]     rd_val;
  logic [DATA_W-1:0]     dir_val;
  fcd_seq_t              seq_r;
  fcd_pd_state_t         pd_r;
  fcd_pd_state_t         pd_nxt;
  logic                  pu_start;
  logic                  pu_busy;
  logic [PU_CNT_W-1:0]   pu_load;
  logic                  wr_cfg;
  logic                  wr_dsr;
  logic                  wr_pts;
  logic                  wr_cmd;
  logic                  auto_powerdown_enable;
  logic                  rate_2m;

  function automatic logic [LEN_W-1:0] sector_bytes(
    input logic [N_W-1:0] n
  );
    sector_bytes = SECT_BASE << n;
  endfunction

  function automatic logic [PU_CNT_W-1:0] pu_cycles(
    input logic min_powerup_delay_sel,
    input logic fast
  );
    int c;
    c = min_powerup_delay_sel ? PU_LONG : PU_SHORT;
    if (fast)
      c = c / 2;
    if (c < 1)
      c = 1;
    pu_cycles = PU_CNT_W'(c);
  endfunction

  function automatic logic [LEN_W-1:0] xfer_bytes(
    input logic [N_W-1:0]    n,
    input logic [BYTE_W-1:0] data_length_param
  );
    if (n == '0)
      xfer_bytes = LEN_W'(data_length_param);
    else
      xfer_bytes = sector_bytes(n);
  endfunction

  assign wr_cfg  = req.wr && req.addr == OFF_CFG;
  assign wr_dsr  = req.wr && req.addr == OFF_DSR;
  assign wr_pts  = req.wr && req.addr == OFF_PTS;
  assign wr_cmd  = req.wr && req.addr == OFF_CMD;
  assign auto_powerdown_enable = cfg_r[CFG_AUTO_POWERDOWN_ENABLE];
  assign rate_2m = dsr_r[DSR_RATE_LSB +: DSR_RATE_W] == RATE_2M;

  // Configuration; the density flag always reads back as MFM.
  always_ff @(posedge clk)
  begin
    if (reset)
      cfg_r <= CFG_RST;
    else if (ce && wr_cfg)
    begin
      cfg_r <= req.wdata[CFG_W-1:0];
      cfg_r[CFG_MFM] <= 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      dsr_r <= DSR_RST;
    else if (ce && wr_dsr)
      dsr_r <= req.wdata[DSR_W-1:0];
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pts_r <= PTS_RST;
      drv_r <= '0;
    end
    else if (ce && wr_pts)
    begin
      pts_r <= req.wdata[NDRV-1:0];
      drv_r <= req.wdata[PTS_DRV_LSB +: DRV_W];
    end
  end

  // Command parameters and the transfer length they imply.
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      n_r    <= '0;
      head_r <= 1'b0;
      sect_r <= SECTOR_FIRST;
      eot_r  <= SECTOR_FIRST;
      dtl_r  <= '0;
      xfer_r <= '0;
    end
    else if (ce && wr_cmd)
    begin
      n_r    <= req.wdata[CMD_N_LSB +: N_W];
      head_r <= req.wdata[CMD_HEAD];
      sect_r <= req.wdata[CMD_SECT_LSB +: BYTE_W];
      eot_r  <= req.wdata[CMD_EOT_LSB +: BYTE_W];
      dtl_r  <= req.wdata[CMD_DTL_LSB +: BYTE_W];
      xfer_r <= xfer_bytes(req.wdata[CMD_N_LSB +: N_W],
                           req.wdata[CMD_DTL_LSB +: BYTE_W]);
    end
  end

  // Sector sequencer; a cylinder is one long track in multi-track mode.
  always_ff @(posedge clk)
  begin
    if (reset)
      seq_r <= '0;
    else if (ce)
    begin
      if (wr_cmd && req.wdata[CMD_START])
      begin
        seq_r.active <= 1'b1;
        seq_r.head   <= req.wdata[CMD_HEAD];
        seq_r.sector <= req.wdata[CMD_SECT_LSB +: BYTE_W];
      end
      else if (seq_r.active && sector_done)
      begin
        if (seq_r.sector != eot_r)
          seq_r.sector <= seq_r.sector + BYTE_W'(1);
        else if (cfg_r[CFG_MT] && !seq_r.head)
        begin
          seq_r.head   <= 1'b1;
          seq_r.sector <= SECTOR_FIRST;
        end
        else
          seq_r.active <= 1'b0;
      end
    end
  end

  // Present cylinder is caught as sense interrupt status completes.
  always_ff @(posedge clk)
  begin
    if (reset)
      pcn_r <= '0;
    else if (ce && sense_done)
      pcn_r <= head_position;
  end

  // Precompensation delay per selected drive.
  always_ff @(posedge clk)
  begin
    if (reset)
      pc_r <= '0;
    else if (ce)
    begin
      if (pts_r[drv_r])
        pc_r <= '0;
      else
        pc_r <= dsr_r[DSR_PC_LSB +: PC_W];
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      osc_en_r <= 1'b1;
    else if (ce)
      osc_en_r <= !cfg_r[CFG_OSC_PD];
  end

  // Automatic powerdown with a minimum time awake, kept only while automatic powerdown stays enabled.
  always_comb
  begin
    pd_nxt   = pd_r;
    pu_start = 1'b0;
    case (pd_r)
      PD_ACTIVE:
        if (auto_powerdown_enable && core_idle)
          pd_nxt = PD_DOWN;
      PD_DOWN:
        if (!auto_powerdown_enable)
          pd_nxt = PD_ACTIVE;
        else if (wake)
        begin
          pd_nxt   = PD_POWERUP;
          pu_start = 1'b1;
        end
      PD_POWERUP:
        if (!auto_powerdown_enable || !pu_busy)
          pd_nxt = PD_ACTIVE;
      default:
        pd_nxt = PD_ACTIVE;
    endcase
  end

  assign pu_load = pu_cycles(cfg_r[CFG_MIN_POWERUP_DELAY_SEL], rate_2m);

  always_ff @(posedge clk)
  begin
    if (reset)
      pd_r <= PD_ACTIVE;
    else if (ce)
      pd_r <= pd_nxt;
  end

  fcd_pu_timer #(
    .CNT_W (PU_CNT_W)
  ) u_pu_timer (
    .clk   (clk),
    .reset (reset),
    .ce    (ce),
    .start (pu_start),
    .load  (pu_load),
    .busy  (pu_busy)
  );

  // Input register status bits, legacy compatible mode only.
  always_comb
  begin
    dir_val = '0;
    if (cfg_r[CFG_COMPAT_MODE] && cfg_r[CFG_COMPAT_STAT]
        && !cfg_r[CFG_IDLE_MSK])
    begin
      dir_val[DIR_PD_BIT]   = pd_r == PD_DOWN;
      dir_val[DIR_IDLE_BIT] = core_idle;
    end
  end

  always_comb
  begin
    rd_val = '0;
    case (req.addr)
      OFF_CFG:  rd_val[CFG_W-1:0] = cfg_r;
      OFF_DSR:  rd_val[DSR_W-1:0] = dsr_r;
      OFF_PTS:
      begin
        rd_val[NDRV-1:0] = pts_r;
        rd_val[PTS_DRV_LSB +: DRV_W] = drv_r;
      end
      OFF_CMD:
      begin
        rd_val[CMD_N_LSB +: N_W] = n_r;
        rd_val[CMD_HEAD] = head_r;
        rd_val[CMD_SECT_LSB +: BYTE_W] = sect_r;
        rd_val[CMD_EOT_LSB +: BYTE_W] = eot_r;
        rd_val[CMD_DTL_LSB +: BYTE_W] = dtl_r;
      end
      OFF_XFER: rd_val[LEN_W-1:0] = xfer_r;
      OFF_PCN:  rd_val[BYTE_W-1:0] = pcn_r;
      OFF_DIR:  rd_val = dir_val;
      OFF_STAT:
      begin
        rd_val[STAT_PD]   = pd_r == PD_DOWN;
        rd_val[STAT_IDLE] = core_idle;
        rd_val[STAT_OSC]  = osc_en_r;
        rd_val[STAT_PU]   = pd_r == PD_POWERUP;
      end
      OFF_SEQ:  rd_val[$bits(fcd_seq_t)-1:0] = seq_r;
      default:  rd_val = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_r <= '0;
    else if (ce)
      rdata_r <= req.rd ? rd_val : '0;
  end

  assign rdata           = rdata_r;
  assign seq             = seq_r;
  assign xfer_len        = xfer_r;
  assign precomp_delay   = pc_r;
  assign osc_enable      = osc_en_r;
  assign powerdown_state = pd_r == PD_DOWN;
  assign mfm_mode        = cfg_r[CFG_MFM];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  AST_MFM_KEPT: assert property (
    mfm_mode)
    else $error("Recording mode left MFM.");

  AST_NO_AUTO_NO_DOWN: assert property (
    ce && !auto_powerdown_enable |=> pd_r == PD_ACTIVE)
    else $error("Powerdown state held with automatic powerdown off.");

  AST_PU_LOAD: assert property (
    pu_start |-> pu_load == (cfg_r[CFG_MIN_POWERUP_DELAY_SEL]
      ? PU_CNT_W'(rate_2m ? PU_LONG / 2 : PU_LONG)
      : PU_CNT_W'(rate_2m ? PU_SHORT / 2 : PU_SHORT)))
    else $error("Wrong minimum power-up count chosen.");

  AST_PU_HOLD: assert property (
    pd_r == PD_POWERUP && pu_busy && auto_powerdown_enable |=> pd_r == PD_POWERUP)
    else $error("Powerdown re-entered before minimum power-up time.");

  AST_MT_WRAP: assert property (
    ce && seq_r.active && sector_done && !wr_cmd && cfg_r[CFG_MT]
      && !seq_r.head && seq_r.sector == eot_r
    |=> seq_r.active && seq_r.head && seq_r.sector == SECTOR_FIRST)
    else $error("Multi-track did not move to head 1.");

  AST_SINGLE_END: assert property (
    ce && seq_r.active && sector_done && !wr_cmd && !cfg_r[CFG_MT]
      && seq_r.sector == eot_r |=> !seq_r.active)
    else $error("Single-track run did not end at last sector.");

  AST_LEN_DTL: assert property (
    ce && wr_cmd && req.wdata[CMD_N_LSB +: N_W] == '0
    |=> xfer_len == LEN_W'($past(req.wdata[CMD_DTL_LSB +: BYTE_W])))
    else $error("Size code 00 did not use the data length.");

  AST_LEN_SIZE: assert property (
    ce && wr_cmd && req.wdata[CMD_N_LSB +: N_W] != '0
    |=> xfer_len == SECT_BASE << $past(req.wdata[CMD_N_LSB +: N_W]))
    else $error("Sector size not 128 shifted by the code.");

  AST_PCN_CAPTURE: assert property (
    ce && sense_done ##1 ce && req.rd && req.addr == OFF_PCN
    |=> rdata[BYTE_W-1:0] == $past(head_position, 2))
    else $error("Present cylinder not captured on sense completion.");

  AST_PRECOMP: assert property (
    ce && wr_dsr && !pts_r[drv_r] && !wr_pts ##1 ce
    |=> precomp_delay == $past(req.wdata[DSR_PC_LSB +: PC_W], 2))
    else $error("Programmed precompensation not applied.");

  AST_NO_PRECOMP: assert property (
    ce && pts_r[drv_r] && !wr_pts |=> precomp_delay == '0)
    else $error("Precompensation applied with table select set.");

  AST_OSC_OFF: assert property (
    ce && wr_cfg && req.wdata[CFG_OSC_PD] ##1 ce |=> !osc_enable)
    else $error("Oscillator still enabled after powerdown bit.");

  AST_DIR_GATED: assert property (
    ce && req.rd && req.addr == OFF_DIR && (!cfg_r[CFG_COMPAT_MODE]
      || !cfg_r[CFG_COMPAT_STAT] || cfg_r[CFG_IDLE_MSK])
    |=> rdata[DIR_PD_BIT] == 1'b0 && rdata[DIR_IDLE_BIT] == 1'b0)
    else $error("Input register status bits shown while disabled.");

  AST_DIR_SHOW: assert property (
    ce && req.rd && req.addr == OFF_DIR && cfg_r[CFG_COMPAT_MODE]
      && cfg_r[CFG_COMPAT_STAT] && !cfg_r[CFG_IDLE_MSK]
    |=> rdata[DIR_PD_BIT] == $past(pd_r == PD_DOWN)
      && rdata[DIR_IDLE_BIT] == $past(core_idle))
    else $error("Input register does not show powerdown and idle.");

  COV_MT_WRAP: cover property (
    seq_r.active && !seq_r.head ##1 seq_r.active && seq_r.head);
  COV_POWERDOWN: cover property (pd_r == PD_ACTIVE ##1 pd_r == PD_DOWN);
  COV_POWERUP_DONE: cover property (
    pd_r == PD_POWERUP ##1 pd_r == PD_ACTIVE);

endmodule

// [fcd_host_model.sv]
`timescale 1ns/1ps
module fcd_host_model
(
  input  wire logic                          clk,
  output fcd_pkg::fcd_reg_req_t              req,
  input  wire logic [fcd_pkg::DATA_W-1:0]    rdata
);
  import fcd_pkg::*;

  initial req = '0;

  // One write cycle; the strobe drops at the edge that takes it.
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    req <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic set_cfg(input logic [CFG_W-1:0] v);
    logic [CFG_W-1:0] c;
    c = v;
    c[CFG_MFM] = 1'b1;
    wr(OFF_CFG, DATA_W'(c));
  endtask

  // Size codes are limited to the field width, so no code above 07 is sent.
  task automatic cmd(input logic [N_W-1:0] n, input logic hd,
                     input logic [BYTE_W-1:0] s, e, l);
    wr(OFF_CMD, {l, e, s, 3'h0, 1'b1, hd, n});
  endtask
endmodule

// [test_fcd_command_parameter_decode.sv]
`timescale 1ns/1ps
module test_fdc_command_parameter_decode;
  import fcd_pkg::*;

  localparam int PU_S = 20;
  localparam int PU_L = 40;

  logic                 clk;
  logic                 reset;
  logic                 ce;
  logic                 core_idle;
  logic                 wake;
  logic                 sense_done;
  logic [BYTE_W-1:0]    head_position;
  logic                 sector_done;
  fcd_reg_req_t         req;
  logic [DATA_W-1:0]    rdata;
  fcd_seq_t             seq;
  logic [LEN_W-1:0]     xfer_len;
  logic [PC_W-1:0]      precomp_delay;
  logic                 osc_enable;
  logic                 powerdown_state;
  logic                 mfm_mode;
  logic [DATA_W-1:0]    d;
  int                   fails;
  int                   n_checks;

  fcd_top #(.PU_SHORT(PU_S), .PU_LONG(PU_L)) i_dut (
    .clk            (clk),
    .reset          (reset),
    .ce             (ce),
    .req            (req),
    .rdata          (rdata),
    .core_idle      (core_idle),
    .wake           (wake),
    .sense_done     (sense_done),
    .head_position  (head_position),
    .sector_done    (sector_done),
    .seq            (seq),
    .xfer_len       (xfer_len),
    .precomp_delay  (precomp_delay),
    .osc_enable     (osc_enable),
    .powerdown_state(powerdown_state),
    .mfm_mode       (mfm_mode)
  );

  fcd_host_model i_host (
    .clk  (clk),
    .req  (req),
    .rdata(rdata)
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, exp, input string msg);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("BAD %0t %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic wait_pd;
    int k;
    k = 0;
    while (powerdown_state !== 1'b1 && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    chk(32'(powerdown_state), 32'h1, "enter powerdown");
  endtask

  task automatic t_reset;
    i_host.rd(OFF_CFG, d);
    chk(d, 32'h0000_0001, "cfg reset");
    chk(32'(mfm_mode), 32'h1, "mfm");
    chk(32'(osc_enable), 32'h1, "osc reset");
    i_host.rd(8'h3C, d);
    chk(d, 32'h0, "unmapped read");
    // Deliberately clears the density flag, which software must not do.
    i_host.wr(OFF_CFG, 32'h0);
    i_host.rd(OFF_CFG, d);
    chk(d, 32'h0000_0001, "mfm kept");
    chk(32'(mfm_mode), 32'h1, "mfm out");
  endtask

  task automatic pc_chk(input logic [DATA_W-1:0] precomp_table_select,
                        input logic [PC_W-1:0] exp);
    i_host.wr(OFF_PTS, precomp_table_select);
    repeat (2) @(posedge clk);
    #1 chk(32'(precomp_delay), 32'(exp), "precomp");
  endtask

  task automatic t_pc;
    i_host.wr(OFF_DSR, 32'h0000_0014);
    repeat (2) @(posedge clk);
    #1 chk(32'(precomp_delay), 32'h5, "pc default");
    pc_chk(32'h0000_0001, 3'h0);
    pc_chk(32'h0000_0011, 3'h5);
    pc_chk(32'h0000_0000, 3'h5);
  endtask

  task automatic t_size;
    logic [LEN_W-1:0] exp;
    for (int n = 0; n < 8; n++)
    begin
      i_host.cmd(N_W'(n), 1'b0, 8'h01, 8'h01, 8'h40);
      repeat (2) @(posedge clk);
      exp = (n == 0) ? 16'h0040 : LEN_W'(128 << n);
      #1 chk(32'(xfer_len), 32'(exp), "xfer_len");
    end
  endtask

  task automatic t_seq;
    fcd_seq_t e;
    for (int mt = 0; mt < 2; mt++)
    begin
      i_host.set_cfg(CFG_W'(mt) << CFG_MT);
      i_host.cmd(3'h1, 1'b0, 8'h01, 8'h02, 8'h00);
      e = '{active: 1'b1, head: 1'b0, sector: 8'h01};
      #1 chk({22'h0, seq}, {22'h0, e}, "seq start");
      while (e.active)
      begin
        @(posedge clk);
        sector_done <= 1'b1;
        @(posedge clk);
        sector_done <= 1'b0;
        if (e.sector < 8'h02)
          e.sector++;
        else if (mt == 1 && !e.head)
          e = '{active: 1'b1, head: 1'b1, sector: 8'h01};
        else
          e.active = 1'b0;
        #1;
        if (e.active)
          chk({22'h0, seq}, {22'h0, e}, "seq step");
        else
          chk(32'(seq.active), 32'h0, "seq end");
      end
    end
  endtask

  task automatic t_pcn;
    for (int i = 0; i < 2; i++)
    begin
      @(posedge clk);
      head_position <= 8'h2A + 8'(i * 9);
      sense_done <= 1'b1;
      @(posedge clk);
      sense_done <= 1'b0;
      head_position <= 8'h77;
      i_host.rd(OFF_PCN, d);
      chk(d, 32'h2A + 32'(i * 9), "pcn");
    end
  endtask

  task automatic t_pd;
    int load;
    logic [CFG_W-1:0] c;
    c = '0;
    c[CFG_MIN_POWERUP_DELAY_SEL] = 1'b1;
    i_host.set_cfg(c);
    core_idle <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'(powerdown_state), 32'h0, "no auto_powerdown_enable");
    i_host.rd(OFF_STAT, d);
    chk(32'(d[STAT_PU]), 32'h0, "no hold");
    for (int i = 0; i < 4; i++)
    begin
      load = (i[0] ? PU_L : PU_S) >> i[1];
      i_host.wr(OFF_DSR, i[1] ? 32'(RATE_2M) : 32'h0);
      c[CFG_MIN_POWERUP_DELAY_SEL] = i[0];
      c[CFG_AUTO_POWERDOWN_ENABLE] = 1'b1;
      core_idle <= 1'b1;
      i_host.set_cfg(c);
      wait_pd();
      core_idle <= 1'b0;
      @(posedge clk);
      wake <= 1'b1;
      @(posedge clk);
      wake <= 1'b0;
      repeat (load - 5) @(posedge clk);
      i_host.rd(OFF_STAT, d);
      chk(32'(d[STAT_PU]), 32'h1, "still held");
      repeat (5) @(posedge clk);
      i_host.rd(OFF_STAT, d);
      chk(32'(d[STAT_PU]), 32'h0, "released");
    end
    i_host.set_cfg('0);
  endtask

  task automatic t_dir;
    logic [CFG_W-1:0] c;
    c = '0;
    c[CFG_AUTO_POWERDOWN_ENABLE] = 1'b1;
    c[CFG_COMPAT_STAT] = 1'b1;
    c[CFG_COMPAT_MODE] = 1'b1;
    core_idle <= 1'b1;
    i_host.set_cfg(c);
    wait_pd();
    i_host.rd(OFF_DIR, d);
    chk(32'(d[DIR_PD_BIT]), 32'h1, "dir pd");
    chk(32'(d[DIR_IDLE_BIT]), 32'h1, "dir idle");
    c[CFG_IDLE_MSK] = 1'b1;
    i_host.set_cfg(c);
    i_host.rd(OFF_DIR, d);
    chk(d & 32'hC0, 32'h0, "dir masked");
    c[CFG_IDLE_MSK] = 1'b0;
    c[CFG_COMPAT_MODE] = 1'b0;
    i_host.set_cfg(c);
    i_host.rd(OFF_DIR, d);
    chk(d & 32'hC0, 32'h0, "dir other mode");
    core_idle <= 1'b0;
    i_host.set_cfg('0);
  endtask

  task automatic t_osc;
    // A write made while the clock enable is low must be lost.
    @(posedge clk);
    ce <= 1'b0;
    i_host.set_cfg(CFG_W'(1) << CFG_OSC_PD);
    ce <= 1'b1;
    repeat (2) @(posedge clk);
    #1 chk(32'(osc_enable), 32'h1, "ce freeze");
    // The bench stands for a board with an external oscillator fitted.
    i_host.set_cfg(CFG_W'(1) << CFG_OSC_PD);
    repeat (2) @(posedge clk);
    #1 chk(32'(osc_enable), 32'h0, "osc off");
    i_host.set_cfg('0);
    repeat (2) @(posedge clk);
    #1 chk(32'(osc_enable), 32'h1, "osc on");
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    $display("BAD %0t run did not finish", $time);
    stop_test();
  end

  initial
  begin
    fails = 0;
    n_checks = 0;
    reset = 1'b1;
    ce = 1'b1;
    core_idle = 1'b0;
    wake = 1'b0;
    sense_done = 1'b0;
    head_position = '0;
    sector_done = 1'b0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    t_reset();
    t_pc();
    t_size();
    t_seq();
    t_pcn();
    t_pd();
    t_dir();
    t_osc();
    stop_test();
  end
endmodule
